// *** dv/fsg_regs_properties.sv ***
`timescale 1ns/1ps
// Port-level checks on the register bus and decoded outputs.
module fsg_regs_props
(
	input wire logic               aclk,
	input wire logic               aresetn,
	input wire logic               s_axi_arvalid,
	input wire logic               s_axi_arready,
	input wire logic               s_axi_rvalid,
	input wire logic               s_axi_rready,
	input wire logic        [31:0] s_axi_rdata,
	input wire logic               s_axi_bvalid,
	input wire logic               s_axi_bready,
	input wire logic        [1:0]  s_axi_bresp,
	input wire logic               frame_sync_rate,
	input wire logic        [7:0]  divider_m,
	input wire logic        [4:0]  divider_n,
	input wire logic        [3:0]  divider_p,
	input wire logic signed [7:0]  adc_gain_hdb,
	input wire logic               adc_mute,
	input wire logic signed [7:0]  dac_gain_hdb
);
	// One clock domain, so one clocking and one reset serve every check.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// The all-zero field stands for the largest value, so zero never appears.
	property p_m_rng; divider_m != 8'h00 && divider_m <= 8'h80; endproperty
	a_m_rng: assert property (p_m_rng) else $error("M out of range");
	property p_n_rng; divider_n != 5'h00 && divider_n <= 5'h10; endproperty
	a_n_rng: assert property (p_n_rng) else $error("N out of range");
	property p_p_rng; divider_p != 4'h0 && divider_p <= 4'h8; endproperty
	a_p_rng: assert property (p_p_rng) else $error("P out of range");
	// The smallest ratio is sixteen, so a pulse is followed by quiet cycles.
	property p_fs_gap; frame_sync_rate |=> (!frame_sync_rate) [*8]; endproperty
	a_fs_gap: assert property (p_fs_gap) else $error("frame sync too soon");
	// Gains stay inside the decoded span.
	property p_adc_rng; !adc_gain_hdb[7] && adc_gain_hdb <= 8'sh6c; endproperty
	a_adc_rng: assert property (p_adc_rng) else $error("ADC gain out of span");
	property p_dac_rng; dac_gain_hdb <= 8'sh00 && dac_gain_hdb >= 8'sh94; endproperty
	a_dac_rng: assert property (p_dac_rng) else $error("DAC gain out of span");
	// Bus answers hold until accepted, and an accepted read is answered on the next cycle.
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_ar_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
	a_ar_ans: assert property (p_ar_ans) else $error("read not answered");

	c_fs: cover property (frame_sync_rate);
	c_err: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
	c_mute: cover property (adc_mute);
endmodule

bind fsg_regs fsg_regs_props i_fsg_regs_props
(
	.aclk            (aclk),
	.aresetn         (aresetn),
	.s_axi_arvalid   (s_axi_arvalid),
	.s_axi_arready   (s_axi_arready),
	.s_axi_rvalid    (s_axi_rvalid),
	.s_axi_rready    (s_axi_rready),
	.s_axi_rdata     (s_axi_rdata),
	.s_axi_bvalid    (s_axi_bvalid),
	.s_axi_bready    (s_axi_bready),
	.s_axi_bresp     (s_axi_bresp),
	.frame_sync_rate (frame_sync_rate),
	.divider_m       (divider_m),
	.divider_n       (divider_n),
	.divider_p       (divider_p),
	.adc_gain_hdb    (adc_gain_hdb),
	.adc_mute        (adc_mute),
	.dac_gain_hdb    (dac_gain_hdb)
);

// *** dv/fsg_regs_test.sv ***
`timescale 1ns/1ps
// Self-checking bench for the divider and gain registers.
module fsg_regs_test;
	import fsg_pkg::*;
	logic              aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        [7:0] s_axi_awaddr, s_axi_araddr, divider_m;
	logic       [31:0] s_axi_wdata, s_axi_rdata;
	logic        [3:0] s_axi_wstrb, divider_p;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        [1:0] s_axi_bresp, s_axi_rresp;
	logic              frame_sync_rate, adc_mute, dac_mute;
	logic        [4:0] divider_n;
	logic signed [7:0] adc_gain_hdb, dac_gain_hdb;
	int                err_count, n_tests;

	// Every port is tied by name so a renamed pin cannot slip through unnoticed.
	fsg_regs i_fsg_regs
	(
		.aclk            (aclk),
		.aresetn         (aresetn),
		.s_axi_awaddr    (s_axi_awaddr),
		.s_axi_awvalid   (s_axi_awvalid),
		.s_axi_awready   (s_axi_awready),
		.s_axi_wdata     (s_axi_wdata),
		.s_axi_wstrb     (s_axi_wstrb),
		.s_axi_wvalid    (s_axi_wvalid),
		.s_axi_wready    (s_axi_wready),
		.s_axi_bresp     (s_axi_bresp),
		.s_axi_bvalid    (s_axi_bvalid),
		.s_axi_bready    (s_axi_bready),
		.s_axi_araddr    (s_axi_araddr),
		.s_axi_arvalid   (s_axi_arvalid),
		.s_axi_arready   (s_axi_arready),
		.s_axi_rdata     (s_axi_rdata),
		.s_axi_rresp     (s_axi_rresp),
		.s_axi_rvalid    (s_axi_rvalid),
		.s_axi_rready    (s_axi_rready),
		.frame_sync_rate (frame_sync_rate),
		.divider_m       (divider_m),
		.divider_n       (divider_n),
		.divider_p       (divider_p),
		.adc_gain_hdb    (adc_gain_hdb),
		.adc_mute        (adc_mute),
		.dac_gain_hdb    (dac_gain_hdb),
		.dac_mute        (dac_mute)
	);

	// Free-running 250 MHz clock.
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// Counts one comparison and reports a mismatch.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
			err_count++;
		if (got !== exp)
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
	endtask

	// One write; each channel is released at the edge that takes it.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	endtask

	// One read; data and code are taken at the edge that accepts them.
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, ed);
		chk(s_axi_rresp, er);
	endtask

	// Measures the gap between two later pulses; the first may be an early wrap.
	task automatic t_period(input int exp);
		int n;
		n = 0;
		repeat (2)
		begin
			@(posedge aclk);
			while (!frame_sync_rate) @(posedge aclk);
		end
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (!frame_sync_rate);
		chk(n, exp);
	endtask

	// Divider fields: each write reaches only the set its top bit picks.
	task automatic t_div;
		wr(OFS_DIVIDER, 32'h81, RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk(divider_m, 8'h01);
		chk(divider_n, 5'h10);
		wr(OFS_DIVIDER, 32'h09, RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk(divider_n, 5'h01);
		chk(divider_p, 4'h1);
		chk(divider_m, 8'h01);
		rd(OFS_DIV_STATUS, 32'h10, RESP_OKAY);
		t_period(16);
		wr(OFS_DIVIDER, 32'hff, RESP_OKAY);
		wr(OFS_DIVIDER, 32'h7f, RESP_OKAY);
		repeat (3) @(posedge aclk);
		rd(OFS_DIV_STATUS, 32'h34170, RESP_OKAY);
		rd(OFS_DIVIDER, 32'h7f, RESP_OKAY);
	endtask

	// Walks codes 0 to 31 of one gain subregister.
	task automatic t_gain(input logic [1:0] sub);
		logic signed [7:0] e;
		for (int c = 0; c < 32; c++)
		begin
			wr(OFS_GAIN, {24'h0, sub, c[5:0]}, RESP_OKAY);
			repeat (2) @(posedge aclk);
			e = (c == 29) ? 8'sh60 : (c == 30) ? 8'sh6c : 8'(3 * c);
			if (sub == SUB_ADC)
				chk(adc_mute, c == 31);
			if (sub == SUB_ADC && c < 31)
				chk(adc_gain_hdb, e);
			if (sub == SUB_DAC)
				chk(dac_mute, c == 31);
			if (sub == SUB_DAC && c < 31)
				chk(dac_gain_hdb, -e);
		end
		rd(OFS_GAIN, {24'h0, sub, 6'h1f}, RESP_OKAY);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Cuts a hang short; the full run needs well under this.
	initial
	begin
		#40000;
		err_count++;
		tally_and_finish();
	end

	// Main sequence.
	initial
	begin
		err_count = 0;
		n_tests = 0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'h1;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(divider_m, 8'h80);
		chk(divider_n, 5'h10);
		chk(divider_p, 4'h8);
		rd(OFS_DIV_STATUS, 32'h40000, RESP_OKAY);
		t_div();
		t_gain(SUB_ADC);
		t_gain(SUB_DAC);
		chk(adc_mute, 1'b1);
		wr(OFS_GAIN, 32'h85, RESP_OKAY);
		rd(OFS_GAIN, 32'h5f, RESP_OKAY);
		// An unmapped place is refused; a read-only one ignores writes.
		wr(8'h10, 32'h0, RESP_SLVERR);
		rd(8'h10, 32'h0, RESP_SLVERR);
		wr(OFS_DIV_STATUS, 32'h0, RESP_OKAY);
		rd(OFS_DIV_STATUS, 32'h34170, RESP_OKAY);
		// A write with lane zero switched off is answered but leaves the divider alone.
		s_axi_wstrb <= 4'h0;
		wr(OFS_DIVIDER, 32'h81, RESP_OKAY);
		s_axi_wstrb <= 4'h1;
		rd(OFS_DIVIDER, 32'h7f, RESP_OKAY);
		// A code with its top bit set mutes; both channels then read muted at zero gain.
		wr(OFS_GAIN, 32'h20, RESP_OKAY);
		rd(OFS_GAIN_STATUS, 32'h30000, RESP_OKAY);
		tally_and_finish();
	end
endmodule

// *** logic/fsg_gain_decode.sv ***
`timescale 1ns/1ps
// Turns a six-bit gain code into a signed gain in half decibels and a mute flag.
module fsg_gain_decode
#(
	parameter bit ATTEN = 1'b0
)
(
	input  wire logic        [5:0] code,
	output logic signed      [7:0] gain_hdb,
	output logic                   mute
);
	import fsg_pkg::*;

	// Magnitude before the sign for attenuation is applied.
	logic [7:0] mag;

	// Pure decode; the caller registers the result.
	always_comb
	begin
		mag  = 8'h00;
		mute = 1'b0;
		if (code[CODE_MSB])
		begin
			// Codes with the top bit set are undefined, so they mute rather than blast.
			mute = 1'b1;
		end
		else if (code <= CODE_LINEAR_MAX)
		begin
			// Three half decibels per step, done as code plus twice code.
			mag = {2'h0, code} + {1'h0, code, 1'h0};
		end
		else if (code == CODE_48DB)
		begin
			mag = GAIN_48DB_HDB;
		end
		else if (code == CODE_54DB)
		begin
			mag = GAIN_54DB_HDB;
		end
		else
		begin
			mute = 1'b1;
		end
		// The DAC path reads the same table as attenuation.
		gain_hdb = ATTEN ? -$signed(mag) : $signed(mag);
	end

endmodule

// *** logic/fsg_regs.sv ***
`timescale 1ns/1ps
// Divider and gain control registers behind an AXI4-Lite slave.
module fsg_regs
(
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic               [7:0]  s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic               [31:0] s_axi_wdata,
	input  wire logic               [3:0]  s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic                    [1:0]  s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic               [7:0]  s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic                    [31:0] s_axi_rdata,
	output logic                    [1:0]  s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output logic                           frame_sync_rate,
	output logic                    [7:0]  divider_m,
	output logic                    [4:0]  divider_n,
	output logic                    [3:0]  divider_p,
	output logic signed             [7:0]  adc_gain_hdb,
	output logic                           adc_mute,
	output logic signed             [7:0]  dac_gain_hdb,
	output logic                           dac_mute
);
	import fsg_pkg::*;

	// Every flip-flop of the block lives in this one record.
	typedef struct packed {
		// Write address channel state.
		logic              awready;
		logic              have_aw;
		logic [7:0]        aw_addr;
		// Write data channel state.
		logic              wready;
		logic              have_w;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		// Write response channel.
		logic              bvalid;
		logic [1:0]        bresp;
		// Read channels.
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		// Divider register contents.
		logic              sel_last;
		logic [6:0]        m_code;
		logic [3:0]        n_code;
		logic [2:0]        p_code;
		// Gain register contents.
		logic [1:0]        sub_last;
		logic [5:0]        adc_code;
		logic [5:0]        dac_code;
		// Decoded divider values and the total ratio.
		logic [7:0]        m_val;
		logic [4:0]        n_val;
		logic [3:0]        p_val;
		logic [DIV_W-1:0]  divisor;
		// Frame sync counter and its pulse.
		logic [DIV_W-1:0]  count;
		logic              fs_pulse;
		// Registered gain decode results.
		logic [7:0]        adc_gain;
		logic              adc_mute;
		logic [7:0]        dac_gain;
		logic              dac_mute;
	} fsg_state_t;

	// Present state and its next value.
	fsg_state_t state_q;
	fsg_state_t state_d;

	// Codes for both gain channels, index zero is ADC, one is DAC.
	logic [5:0]        ch_code [2];
	// Decoded gain of each channel.
	logic signed [7:0] ch_gain [2];
	// Decoded mute of each channel.
	logic              ch_mute [2];

	// Full ratio before it is cut to the counter width.
	logic [31:0]       ratio_full;
	// Write strobe towards the register file, high for one cycle.
	logic              wr_fire;
	// Lane zero carries every writable register, so only it matters.
	logic [7:0]        wr_byte;

	assign ch_code[0] = state_q.adc_code;
	assign ch_code[1] = state_q.dac_code;

	// One decoder per channel; the DAC one negates the table.
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_gain
			fsg_gain_decode
			#(
				.ATTEN (ch == 1)
			)
			u_dec
			(
				.code     (ch_code[ch]),
				.gain_hdb (ch_gain[ch]),
				.mute     (ch_mute[ch])
			);
		end
	endgenerate

	// Read data for a given address; reserved bits read as zero.
	function automatic logic [32:0] read_word(input fsg_state_t s, input logic [7:0] addr);
		logic [32:0] r;
		r = 33'h000000000;
		case (addr)
			OFS_DIVIDER:
			begin
				// The word shows the field set that the last write aimed at.
				if (s.sel_last)
				begin
					r[7:0] = {1'b1, s.m_code};
				end
				else
				begin
					r[7:0] = {1'b0, s.n_code, s.p_code};
				end
			end
			OFS_GAIN:
			begin
				// The gain word shows the ADC or DAC subregister, whichever was last written.
				if (s.sub_last == SUB_DAC)
				begin
					r[7:0] = {SUB_DAC, s.dac_code};
				end
				else
				begin
					r[7:0] = {SUB_ADC, s.adc_code};
				end
			end
			OFS_DIV_STATUS:
			begin
				// Live ratio, so software can check the frame rate it will get.
				r[DIV_W-1:0] = s.divisor;
			end
			OFS_GAIN_STATUS:
			begin
				// Decoded gains and mutes as the analog side sees them.
				r[17:0] = {s.dac_mute, s.adc_mute, s.dac_gain, s.adc_gain};
			end
			default:
			begin
				// Unmapped address; the top bit flags the error.
				r[32] = 1'b1;
			end
		endcase
		return r;
	endfunction

	// Next-state logic for the bus slave, the registers and the divider.
	always_comb
	begin
		logic [32:0] rd;
		rd         = 33'h000000000;
		state_d    = state_q;
		wr_fire    = 1'b0;
		wr_byte    = state_q.wdata[7:0];
		ratio_full = 32'h00000000;

		// Capture the write address; the slave waits for the data in either order.
		if (s_axi_awvalid && state_q.awready)
		begin
			state_d.have_aw = 1'b1;
			state_d.aw_addr = s_axi_awaddr;
		end

		// Capture the write data with its strobes.
		if (s_axi_wvalid && state_q.wready)
		begin
			state_d.have_w = 1'b1;
			state_d.wdata  = s_axi_wdata;
			state_d.wstrb  = s_axi_wstrb;
		end

		// Retire a pending response before a new write is done.
		if (state_q.bvalid && s_axi_bready)
		begin
			state_d.bvalid = 1'b0;
		end

		// Both halves held and the response channel free: perform the write.
		if (state_q.have_aw && state_q.have_w && !state_q.bvalid)
		begin
			state_d.have_aw = 1'b0;
			state_d.have_w  = 1'b0;
			state_d.bvalid  = 1'b1;
			state_d.bresp   = RESP_OKAY;
			// A write with lane zero off changes nothing but is still answered.
			wr_fire = state_q.wstrb[0];
			case (state_q.aw_addr)
				OFS_DIVIDER, OFS_GAIN:
				begin
					state_d.bresp = RESP_OKAY;
				end
				OFS_DIV_STATUS, OFS_GAIN_STATUS:
				begin
					// Status words are read only; the write is dropped.
					wr_fire = 1'b0;
				end
				default:
				begin
					wr_fire       = 1'b0;
					state_d.bresp = RESP_SLVERR;
				end
			endcase
		end

		// Divider register write, steered by its top bit.
		if (wr_fire && state_q.aw_addr == OFS_DIVIDER)
		begin
			state_d.sel_last = wr_byte[SEL_BIT];
			if (wr_byte[SEL_BIT])
			begin
				state_d.m_code = wr_byte[M_MSB:0];
			end
			else
			begin
				state_d.n_code = wr_byte[N_MSB:N_LSB];
				state_d.p_code = wr_byte[P_MSB:0];
			end
		end

		// Gain register write, steered by its two top bits.
		if (wr_fire && state_q.aw_addr == OFS_GAIN)
		begin
			case (wr_byte[SUB_MSB:SUB_LSB])
				SUB_ADC:
				begin
					state_d.adc_code = wr_byte[CODE_MSB:0];
					state_d.sub_last = SUB_ADC;
				end
				SUB_DAC:
				begin
					state_d.dac_code = wr_byte[CODE_MSB:0];
					state_d.sub_last = SUB_DAC;
				end
				default:
				begin
					// Other subregisters live elsewhere; the write is ignored here.
					state_d.sub_last = state_q.sub_last;
				end
			endcase
		end

		// Read request: answer on the next edge.
		if (s_axi_arvalid && state_q.arready)
		begin
			rd             = read_word(state_q, s_axi_araddr);
			state_d.rvalid = 1'b1;
			state_d.rdata  = rd[31:0];
			state_d.rresp  = rd[32] ? RESP_SLVERR : RESP_OKAY;
		end
		else if (state_q.rvalid && s_axi_rready)
		begin
			state_d.rvalid = 1'b0;
		end

		// Readies follow the holding state, one transfer at a time per channel.
		state_d.awready = !state_d.have_aw;
		state_d.wready  = !state_d.have_w;
		state_d.arready = !state_d.rvalid;

		// An all-zero field stands for the largest divider.
		state_d.m_val = (state_q.m_code == 7'h00) ? M_FULL : {1'b0, state_q.m_code};
		state_d.n_val = (state_q.n_code == 4'h0) ? N_FULL : {1'b0, state_q.n_code};
		state_d.p_val = (state_q.p_code == 3'h0) ? P_FULL : {1'b0, state_q.p_code};

		// Product of prescale and the three dividers; it always fits the counter.
		ratio_full = 32'(FS_PRESCALE) * 32'(state_q.m_val) * 32'(state_q.n_val) * 32'(state_q.p_val);
		state_d.divisor = ratio_full[DIV_W-1:0];

		// Free-running counter; a shrunk ratio wraps at once instead of running long.
		if (state_q.count >= state_q.divisor - 19'h00001)
		begin
			state_d.count    = '0;
			state_d.fs_pulse = 1'b1;
		end
		else
		begin
			state_d.count    = state_q.count + 19'h00001;
			state_d.fs_pulse = 1'b0;
		end

		// Register the gain decode so the outputs are glitch free.
		state_d.adc_gain = ch_gain[0];
		state_d.adc_mute = ch_mute[0];
		state_d.dac_gain = ch_gain[1];
		state_d.dac_mute = ch_mute[1];
	end

	// Single register stage for the whole record, synchronous reset.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q          <= '0;
			state_q.m_code   <= RST_M_CODE;
			state_q.n_code   <= RST_N_CODE;
			state_q.p_code   <= RST_P_CODE;
			state_q.adc_code <= RST_GAIN;
			state_q.dac_code <= RST_GAIN;
			state_q.m_val    <= M_FULL;
			state_q.n_val    <= N_FULL;
			state_q.p_val    <= P_FULL;
			state_q.divisor  <= RST_DIVISOR;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// Ports come straight from the record.
	assign s_axi_awready   = state_q.awready;
	assign s_axi_wready    = state_q.wready;
	assign s_axi_bvalid    = state_q.bvalid;
	assign s_axi_bresp     = state_q.bresp;
	assign s_axi_arready   = state_q.arready;
	assign s_axi_rvalid    = state_q.rvalid;
	assign s_axi_rdata     = state_q.rdata;
	assign s_axi_rresp     = state_q.rresp;
	assign frame_sync_rate = state_q.fs_pulse;
	assign divider_m       = state_q.m_val;
	assign divider_n       = state_q.n_val;
	assign divider_p       = state_q.p_val;
	assign adc_gain_hdb    = state_q.adc_gain;
	assign adc_mute        = state_q.adc_mute;
	assign dac_gain_hdb    = state_q.dac_gain;
	assign dac_mute        = state_q.dac_mute;

endmodule

// *** shared/fsg_pkg.sv ***
// What this block does
// - Frame sync is master clock over 16*M*N*P.
// - Selector one: low seven bits load M.
// - Selector zero: bits six to three load N.
// - Selector zero: bits two to zero load P.
// - Top divider bit routes the write.
// - ADC code 011111 mutes the input path.
// - ADC codes up to 011100 step 1.5 dB.
// - ADC code 011101 gives 48 dB.
// - ADC code 011110 gives 54 dB.
// - DAC codes decode as attenuation, 011100 is -42 dB.
// - DAC code 011011 gives -40.5 dB.
package fsg_pkg;

	// Byte offsets of the words on the register bus.
	localparam logic [7:0] OFS_DIVIDER     = 8'h00;
	localparam logic [7:0] OFS_GAIN        = 8'h04;
	localparam logic [7:0] OFS_DIV_STATUS  = 8'h08;
	localparam logic [7:0] OFS_GAIN_STATUS = 8'h0c;

	// Field positions inside the divider byte.
	localparam int SEL_BIT = 7;
	localparam int M_MSB   = 6;
	localparam int N_MSB   = 6;
	localparam int N_LSB   = 3;
	localparam int P_MSB   = 2;

	// Field positions and subregister codes of the gain byte.
	localparam int         SUB_MSB  = 7;
	localparam int         SUB_LSB  = 6;
	localparam int         CODE_MSB = 5;
	localparam logic [1:0] SUB_ADC  = 2'h0;
	localparam logic [1:0] SUB_DAC  = 2'h1;

	// Fixed prescale in front of the three dividers.
	localparam int FS_PRESCALE = 16;

	// Width of the total divide ratio; the largest ratio is two to the eighteenth.
	localparam int DIV_W = 19;

	// Values after reset; an all-zero field means the largest divider.
	localparam logic [6:0]       RST_M_CODE  = 7'h00;
	localparam logic [3:0]       RST_N_CODE  = 4'h0;
	localparam logic [2:0]       RST_P_CODE  = 3'h0;
	localparam logic [5:0]       RST_GAIN    = 6'h00;
	localparam logic [DIV_W-1:0] RST_DIVISOR = 19'h40000;

	// Largest values that the all-zero field stands for.
	localparam logic [7:0] M_FULL = 8'h80;
	localparam logic [4:0] N_FULL = 5'h10;
	localparam logic [3:0] P_FULL = 4'h8;

	// Special gain codes; gains are counted in half decibels.
	localparam logic [5:0] CODE_LINEAR_MAX = 6'h1c;
	localparam logic [5:0] CODE_48DB       = 6'h1d;
	localparam logic [5:0] CODE_54DB       = 6'h1e;
	localparam logic [5:0] CODE_MUTE       = 6'h1f;
	localparam logic [7:0] GAIN_48DB_HDB   = 8'h60;
	localparam logic [7:0] GAIN_54DB_HDB   = 8'h6c;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
